/* rtl/hmps_pkg.sv */
`default_nettype none
package hmps_pkg;

    // ==========================================================
    // Window and register map
    localparam int unsigned       HMPS_WIN_BYTES    = 32'h0020_0000;
    localparam int unsigned       HMPS_PERIPH_BYTES = 32'h0000_D000;
    localparam int unsigned       HMPS_AW           = $clog2(HMPS_WIN_BYTES);
    localparam logic [HMPS_AW-1:0] HMPS_PERIPH_BASE = HMPS_AW'(HMPS_WIN_BYTES - HMPS_PERIPH_BYTES);
    localparam logic [HMPS_AW-1:0] HMPS_BEAT_BYTES  = 21'h0_0004;
    localparam logic [11:0]       HMPS_OFS_CTRL     = 12'h000;
    localparam logic [11:0]       HMPS_OFS_MODE     = 12'h004;
    localparam logic [11:0]       HMPS_OFS_STATUS   = 12'h008;
    localparam logic [11:0]       HMPS_OFS_MASK     = 12'h00C;
    localparam logic [11:0]       HMPS_OFS_COUNT    = 12'h010;

    // ==========================================================
    // Fields and reset values
    localparam int unsigned       HMPS_CTRL_EN      = 0;
    localparam int unsigned       HMPS_CTRL_ERREN   = 1;
    localparam logic [1:0]        HMPS_CTRL_RST     = 2'h3;
    localparam int unsigned       HMPS_EV_DONE      = 0;
    localparam int unsigned       HMPS_EV_ERR       = 1;
    localparam int unsigned       HMPS_EV_BAD       = 2;
    localparam int unsigned       HMPS_EV_W         = 3;
    localparam int unsigned       HMPS_MODE_LAT_BIT = 8;
    localparam int unsigned       HMPS_MODE_STR_BIT = 4;
    localparam logic [1:0]        HMPS_STRAP_SETTLE = 2'h2;

    // ==========================================================
    // Types
    typedef enum logic [1:0] {
        HMPS_MODE_NONE  = 2'h0,
        HMPS_MODE_ASYNC = 2'h1,
        HMPS_MODE_SYNC  = 2'h3,
        HMPS_MODE_BURST = 2'h2
    } hmps_mode_t;

    typedef enum logic [1:0] {
        HMPS_ST_IDLE = 2'h0,
        HMPS_ST_BUSY = 2'h1,
        HMPS_ST_DONE = 2'h3
    } hmps_st_t;

    typedef struct packed {
        logic port;
        logic burst;
        logic sync;
        logic mux;
    } hmps_strap_t;

    typedef struct packed {
        hmps_strap_t  strap;
        logic         bus_clk;
        logic         cs_n;
        logic         page_n;
        logic [19:0]  addr;
        logic         rd_n;
        logic         wr_n;
        logic [3:0]   bw_n;
        logic [3:0]   be_n;
        logic [31:0]  wdata;
    } hmps_pins_t;

    typedef struct packed {
        logic               valid;
        logic               write;
        logic               periph;
        logic [HMPS_AW-1:0] addr;
        logic [31:0]        wdata;
        logic [3:0]         be;
    } hmps_req_t;

    typedef struct packed {
        logic        ack;
        logic        err;
        logic [31:0] rdata;
    } hmps_rsp_t;

    // ==========================================================
    // Decoding
    function automatic hmps_mode_t hmps_decode(input hmps_strap_t s);
        hmps_mode_t m;
        m = HMPS_MODE_NONE;
        if (s.port)
        begin
            case ({s.burst, s.sync, s.mux})
                3'h0:    m = HMPS_MODE_ASYNC;
                3'h2:    m = HMPS_MODE_SYNC;
                3'h7:    m = HMPS_MODE_BURST;
                default: m = HMPS_MODE_NONE;
            endcase
        end
        return m;
    endfunction

    function automatic logic hmps_strap_bad(input hmps_strap_t s);
        return s.port && (hmps_decode(s) == HMPS_MODE_NONE);
    endfunction

    function automatic logic hmps_in_periph(input logic [HMPS_AW-1:0] a);
        return a >= HMPS_PERIPH_BASE;
    endfunction

endpackage
`default_nettype wire

/* rtl/hmps_sync.sv */
`timescale 1ns/1ns
`default_nettype none
module hmps_sync #(
    parameter int unsigned W = 1
) (
    input  wire logic         clk,
    input  wire logic         rst,
    input  wire logic [W-1:0] d,
    output var  logic [W-1:0] q
);
    typedef struct packed {
        logic [W-1:0] s2;
        logic [W-1:0] s1;
    } hmps_sync_t;

    hmps_sync_t r;
    hmps_sync_t n;

    // First stage feeds only the second stage
    always_comb
    begin
        n.s1 = d;
        n.s2 = r.s1;
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            r <= '0;
        else
            r <= n;
    end

    assign q = r.s2;
endmodule
`default_nettype wire

/* rtl/hmps_top.sv */
// Operation
// - Select strap low denies host, keeps memory interface
// - Strap code 1000 gives clockless asynchronous slave
// - Strap code 1010 gives synchronous slave, host clocks
// - All straps high give synchronous burst transfer
// - Mode latched once at release, never switched
// - Host active: host/flash boot, no external memory
// - Decode two megabyte host window internally
// - Top 52 kilobytes map peripheral registers
// - Synchronous mode samples inputs on host clock
`timescale 1ns/1ns
`default_nettype none
module hmps_top (
    input  wire logic                 CLK,
    input  wire logic                 RST,
    input  wire logic                 PSEL,
    input  wire logic                 PENABLE,
    input  wire logic                 PWRITE,
    input  wire logic [11:0]          PADDR,
    input  wire logic [31:0]          PWDATA,
    output var  logic [31:0]          PRDATA,
    output var  logic                 PREADY,
    output var  logic                 PSLVERR,
    input  wire logic                 HOST_PORT_SELECT,
    input  wire logic                 BURST_CONTROLLER_SELECT,
    input  wire logic                 HOST_SYNC_SELECT,
    input  wire logic                 ADDR_DATA_MUX_SELECT,
    input  wire logic                 HOST_BUS_CLOCK,
    input  wire logic                 HOST_CHIP_SELECT_N,
    input  wire logic                 HOST_PAGE_SELECT_N,
    input  wire logic [19:0]          HOST_ADDRESS,
    input  wire logic                 HOST_READ_STROBE_N,
    input  wire logic                 HOST_WRITE_STROBE_N,
    input  wire logic [3:0]           HOST_BYTE_WRITE_N,
    input  wire logic [3:0]           HOST_BYTE_ENABLE_N,
    input  wire logic [31:0]          HOST_DATA_IN,
    output var  logic [31:0]          HOST_DATA_OUT,
    output var  logic                 HOST_DATA_OE,
    output var  logic                 HOST_WAIT_N,
    output var  logic                 HOST_ERROR_N,
    output var  hmps_pkg::hmps_req_t  INT_REQ,
    input  wire hmps_pkg::hmps_rsp_t  INT_RSP,
    output var  logic                 EXT_MEM_MODE,
    output var  logic                 HOST_BOOT_ONLY,
    output var  logic                 IRQ
);
    // ==========================================================
    // State
    typedef struct packed {
        hmps_pkg::hmps_st_t             st;
        hmps_pkg::hmps_mode_t           mode;
        hmps_pkg::hmps_strap_t          strap;
        logic                           latched;
        logic [1:0]                     boot_cnt;
        logic                           clk_prev;
        logic [1:0]                     ctrl;
        logic [hmps_pkg::HMPS_EV_W-1:0] status;
        logic [hmps_pkg::HMPS_EV_W-1:0] mask;
        logic [15:0]                    count;
        hmps_pkg::hmps_req_t            req;
        logic                           rd_act;
        logic                           err;
        logic [31:0]                    rdata;
        logic [31:0]                    prdata;
        logic                           pslverr;
    } hmps_state_t;

    hmps_state_t                    r;
    hmps_state_t                    n;
    hmps_pkg::hmps_pins_t           pin_raw;
    hmps_pkg::hmps_pins_t           pin_s;
    logic                           host_rise;
    logic                           sel;
    logic                           rd;
    logic                           wr;
    logic                           act;
    logic                           start;
    logic                           burst_go;
    logic                           issue;
    logic [hmps_pkg::HMPS_AW-1:0]   next_addr;
    logic [hmps_pkg::HMPS_EV_W-1:0] ev;
    logic [hmps_pkg::HMPS_EV_W-1:0] clr;

    // ==========================================================
    // Pin capture; every host pin, straps included, is foreign to CLK
    // Host words cross on two flops alone; the host holds them for a few CLK
    // periods around each strobe or host clock edge, or a word may tear
    assign pin_raw = {HOST_PORT_SELECT, BURST_CONTROLLER_SELECT, HOST_SYNC_SELECT, ADDR_DATA_MUX_SELECT,
                      HOST_BUS_CLOCK, HOST_CHIP_SELECT_N, HOST_PAGE_SELECT_N, HOST_ADDRESS,
                      HOST_READ_STROBE_N, HOST_WRITE_STROBE_N, HOST_BYTE_WRITE_N, HOST_BYTE_ENABLE_N,
                      HOST_DATA_IN};

    hmps_sync #(
        .W ($bits(hmps_pkg::hmps_pins_t))
    ) u_sync (
        .clk (CLK),
        .rst (RST),
        .d   (pin_raw),
        .q   (pin_s)
    );

    // ==========================================================
    // Host cycle detection
    // All pins pass the same two stages, so a host clock edge seen here
    // still lines up with the data that the host presented at that edge
    assign host_rise = pin_s.bus_clk & ~r.clk_prev;
    assign sel       = ~pin_s.cs_n | ~pin_s.page_n;
    assign rd        = sel & ~pin_s.rd_n;
    assign wr        = sel & ~pin_s.wr_n & pin_s.rd_n;
    assign act       = rd | wr;
    // Asynchronous mode never looks at the host clock
    assign start     = act & ((r.mode == hmps_pkg::HMPS_MODE_ASYNC) | host_rise);
    // Burst beats reuse the held address plus one word
    assign burst_go  = (r.st == hmps_pkg::HMPS_ST_DONE) && (r.mode == hmps_pkg::HMPS_MODE_BURST)
                       && host_rise && act && !r.err;
    assign issue     = burst_go | ((r.st == hmps_pkg::HMPS_ST_IDLE) && (r.mode != hmps_pkg::HMPS_MODE_NONE)
                       && start && r.ctrl[hmps_pkg::HMPS_CTRL_EN]);
    assign next_addr = burst_go ? r.req.addr + hmps_pkg::HMPS_BEAT_BYTES
                                : {pin_s.addr, 1'b0};

    // ==========================================================
    // Next state
    always_comb
    begin
        n = r;
        ev = '0;
        clr = '0;
        n.clk_prev = pin_s.bus_clk;

        // Mode is taken once, after the strap samples have settled
        if (!r.latched)
        begin
            if (r.boot_cnt == hmps_pkg::HMPS_STRAP_SETTLE)
            begin
                n.latched = 1'b1;
                n.strap = pin_s.strap;
                n.mode = hmps_pkg::hmps_decode(pin_s.strap);
                // A prohibited code is treated as no host port and flagged
                ev[hmps_pkg::HMPS_EV_BAD] = hmps_pkg::hmps_strap_bad(pin_s.strap);
            end
            else
            begin
                n.boot_cnt = r.boot_cnt + 2'h1;
            end
        end

        if (issue)
        begin
            n.req.valid = 1'b1;
            n.req.write = wr;
            n.req.addr = next_addr;
            n.req.periph = hmps_pkg::hmps_in_periph(next_addr);
            n.req.wdata = pin_s.wdata;
            n.req.be = wr ? ~pin_s.bw_n : ~pin_s.be_n;
            n.rd_act = rd;
            n.err = 1'b0;
            n.st = hmps_pkg::HMPS_ST_BUSY;
        end
        else
        begin
            case (r.st)
                hmps_pkg::HMPS_ST_IDLE:
                begin
                    // Host port disabled by software: answer with an error, no access
                    if ((r.mode != hmps_pkg::HMPS_MODE_NONE) && start)
                    begin
                        n.err = 1'b1;
                        n.rd_act = rd;
                        ev[hmps_pkg::HMPS_EV_ERR] = 1'b1;
                        n.st = hmps_pkg::HMPS_ST_DONE;
                    end
                end
                hmps_pkg::HMPS_ST_BUSY:
                begin
                    if (INT_RSP.ack)
                    begin
                        n.req.valid = 1'b0;
                        n.err = INT_RSP.err;
                        if (r.rd_act)
                            n.rdata = INT_RSP.rdata;
                        n.count = r.count + 16'h0001;
                        ev[hmps_pkg::HMPS_EV_DONE] = 1'b1;
                        ev[hmps_pkg::HMPS_EV_ERR] = INT_RSP.err;
                        n.st = hmps_pkg::HMPS_ST_DONE;
                    end
                end
                hmps_pkg::HMPS_ST_DONE:
                begin
                    if (!act)
                    begin
                        n.err = 1'b0;
                        n.rd_act = 1'b0;
                        n.st = hmps_pkg::HMPS_ST_IDLE;
                    end
                end
                default:
                begin
                    n.req.valid = 1'b0;
                    n.st = hmps_pkg::HMPS_ST_IDLE;
                end
            endcase
        end

        // Register read data is prepared in the setup phase
        if (PSEL && !PENABLE)
        begin
            n.pslverr = 1'b0;
            case (PADDR)
                hmps_pkg::HMPS_OFS_CTRL:   n.prdata = 32'(r.ctrl);
                hmps_pkg::HMPS_OFS_MODE:   n.prdata = (32'(r.latched) << hmps_pkg::HMPS_MODE_LAT_BIT)
                                                      | (32'(r.strap) << hmps_pkg::HMPS_MODE_STR_BIT)
                                                      | 32'(r.mode);
                hmps_pkg::HMPS_OFS_STATUS: n.prdata = 32'(r.status);
                hmps_pkg::HMPS_OFS_MASK:   n.prdata = 32'(r.mask);
                hmps_pkg::HMPS_OFS_COUNT:  n.prdata = 32'(r.count);
                default:
                begin
                    n.prdata = 32'h0000_0000;
                    n.pslverr = 1'b1;
                end
            endcase
        end

        if (PSEL && PENABLE && PWRITE)
        begin
            case (PADDR)
                hmps_pkg::HMPS_OFS_CTRL:   n.ctrl = PWDATA[1:0];
                hmps_pkg::HMPS_OFS_MASK:   n.mask = PWDATA[hmps_pkg::HMPS_EV_W-1:0];
                hmps_pkg::HMPS_OFS_STATUS: clr = PWDATA[hmps_pkg::HMPS_EV_W-1:0];
                default:                   clr = '0;
            endcase
        end
        // A new event outweighs a clear in the same cycle
        n.status = (r.status & ~clr) | ev;
    end

    always_ff @(posedge CLK or posedge RST)
    begin
        if (RST)
            r <= '{st: hmps_pkg::HMPS_ST_IDLE, mode: hmps_pkg::HMPS_MODE_NONE,
                   ctrl: hmps_pkg::HMPS_CTRL_RST, default: '0};
        else
            r <= n;
    end

    // ==========================================================
    // Outputs
    assign PRDATA         = r.prdata;
    assign PREADY         = 1'b1;
    assign PSLVERR        = r.pslverr & PSEL & PENABLE;
    assign INT_REQ        = r.req;
    assign HOST_DATA_OUT  = r.rdata;
    // Read data and error are not tied to the host clock
    // Drive data only while the read strobe is still seen low
    assign HOST_DATA_OE   = r.rd_act & (r.st == hmps_pkg::HMPS_ST_DONE) & rd;
    assign HOST_WAIT_N    = (r.st != hmps_pkg::HMPS_ST_BUSY);
    assign HOST_ERROR_N   = ~(r.err & r.ctrl[hmps_pkg::HMPS_CTRL_ERREN]);
    // Until the mode is latched the shared pins stay with the memory interface
    assign EXT_MEM_MODE   = ~r.latched | (r.mode == hmps_pkg::HMPS_MODE_NONE);
    assign HOST_BOOT_ONLY = ~EXT_MEM_MODE;
    assign IRQ            = |(r.status & r.mask);

    // ==========================================================
    // Assertions
    default clocking cb @(posedge CLK); endclocking
    default disable iff (RST);

    property p_deny;
        (r.mode == hmps_pkg::HMPS_MODE_NONE) |-> !INT_REQ.valid && HOST_WAIT_N && !HOST_DATA_OE;
    endproperty
    a_deny: assert property (p_deny) else $error("request while host port denied");

    property p_async;
        (r.mode == hmps_pkg::HMPS_MODE_ASYNC) && (r.st == hmps_pkg::HMPS_ST_IDLE) && act
            && r.ctrl[hmps_pkg::HMPS_CTRL_EN] |=> INT_REQ.valid && !HOST_WAIT_N;
    endproperty
    a_async: assert property (p_async) else $error("async strobe not taken");

    property p_sync_edge;
        $rose(INT_REQ.valid) && (r.mode != hmps_pkg::HMPS_MODE_ASYNC) |-> $past(host_rise);
    endproperty
    a_sync_edge: assert property (p_sync_edge) else $error("sync request off host clock");

    property p_burst;
        burst_go |=> INT_REQ.valid && (INT_REQ.addr == $past(INT_REQ.addr) + hmps_pkg::HMPS_BEAT_BYTES);
    endproperty
    a_burst: assert property (p_burst) else $error("burst beat address wrong");

    property p_bad;
        !r.latched ##1 r.latched && hmps_pkg::hmps_strap_bad(r.strap) |->
            (r.mode == hmps_pkg::HMPS_MODE_NONE) && r.status[hmps_pkg::HMPS_EV_BAD];
    endproperty
    a_bad: assert property (p_bad) else $error("prohibited strap not flagged");

    property p_hold;
        r.latched |=> r.latched && $stable(r.mode) && $stable(r.strap);
    endproperty
    a_hold: assert property (p_hold) else $error("mode changed after latch");

    property p_boot;
        r.latched |-> (EXT_MEM_MODE == (r.mode == hmps_pkg::HMPS_MODE_NONE)) && (HOST_BOOT_ONLY != EXT_MEM_MODE);
    endproperty
    a_boot: assert property (p_boot) else $error("boot or memory function mismatch");

    property p_window;
        INT_REQ.valid |-> INT_REQ.periph == (INT_REQ.addr >= hmps_pkg::HMPS_PERIPH_BASE);
    endproperty
    a_window: assert property (p_window) else $error("peripheral region decode wrong");

    property p_wait;
        INT_REQ.valid && INT_RSP.ack |=> !INT_REQ.valid && HOST_WAIT_N && (r.st == hmps_pkg::HMPS_ST_DONE);
    endproperty
    a_wait: assert property (p_wait) else $error("wait not released after answer");

    property p_irq;
        $rose(r.status[hmps_pkg::HMPS_EV_DONE]) && r.mask[hmps_pkg::HMPS_EV_DONE] |-> IRQ;
    endproperty
    a_irq: assert property (p_irq) else $error("interrupt missing");

    // Straps are read once, at the settle count
    property p_latch;
        !r.latched && (r.boot_cnt == hmps_pkg::HMPS_STRAP_SETTLE)
            |=> r.latched && (r.strap == $past(pin_s.strap));
    endproperty
    a_latch: assert property (p_latch) else $error("mode not latched at settle count");

    property p_err_out;
        INT_REQ.valid && INT_RSP.ack && INT_RSP.err && r.ctrl[hmps_pkg::HMPS_CTRL_ERREN] |=> !HOST_ERROR_N;
    endproperty
    a_err_out: assert property (p_err_out) else $error("error output missing after failed access");

    c_async: cover property ((r.mode == hmps_pkg::HMPS_MODE_ASYNC) && ev[hmps_pkg::HMPS_EV_DONE]);
    c_sync:  cover property ((r.mode == hmps_pkg::HMPS_MODE_SYNC) && ev[hmps_pkg::HMPS_EV_DONE]);
    c_burst: cover property (burst_go ##[1:40] ev[hmps_pkg::HMPS_EV_DONE]);
    c_error: cover property (!HOST_ERROR_N);
    c_deny:  cover property (r.latched && EXT_MEM_MODE);
endmodule
`default_nettype wire

/* sim/hmps_host_model.sv */
`timescale 1ns/1ns
`default_nettype none
module hmps_host_model (
    input  wire logic        clk,
    input  wire logic        wait_n,
    input  wire logic        error_n,
    input  wire logic [31:0] bus_in,
    output var  logic        bus_clk,
    output var  logic        cs_n,
    output var  logic [19:0] addr,
    output var  logic        rd_n,
    output var  logic        wr_n,
    output var  logic [3:0]  bw_n,
    output var  logic [3:0]  be_n,
    output var  logic [31:0] data
);
    // ==========================================================
    // Idle pins
    initial
    begin
        bus_clk = 1'b0;
        cs_n    = 1'b1;
        addr    = 20'h0_0000;
        rd_n    = 1'b1;
        wr_n    = 1'b1;
        bw_n    = 4'hF;
        be_n    = 4'hF;
        data    = 32'h0000_0000;
    end

    // ==========================================================
    // One host access, ended after nb answered beats or a bounded wait
    task automatic xfer(input logic w, input logic [19:0] a, input logic [31:0] d, input logic clk_on,
                        input int nb, output int beats, output logic [31:0] q, output logic err);
        logic prev;
        int   n;
        beats = 0;
        err   = 1'b0;
        n     = 0;
        prev  = 1'b1;
        q     = 32'h0000_0000;
        @(posedge clk);
        cs_n <= 1'b0;
        addr <= a;
        data <= d;
        rd_n <= w;
        wr_n <= !w;
        bw_n <= {4{!w}};
        be_n <= 4'h0;
        while (beats < nb && n < 400)
        begin
            @(posedge clk);
            n++;
            if (!error_n)
                err = 1'b1;
            if (wait_n && !prev)
            begin
                beats++;
                q = bus_in;
            end
            prev = wait_n;
            // Host clock runs only inside the access, 160 ns period
            if (clk_on && beats < nb && n % 10 == 0)
                bus_clk <= ~bus_clk;
        end
        cs_n <= 1'b1;
        rd_n <= 1'b1;
        wr_n <= 1'b1;
        bw_n <= 4'hF;
        be_n <= 4'hF;
        // Released lines must not keep the last value
        addr <= ~a;
        data <= ~d;
        repeat (8) @(posedge clk);
    endtask
endmodule
`default_nettype wire

/* sim/hmps_top_bench.sv */
`timescale 1ns/1ns
`default_nettype none
module hmps_top_bench;
    logic                  clk, rst, psel, penable, pwrite, pready, pslverr, rsp_err;
    logic [11:0]           paddr;
    logic [31:0]           pwdata, prdata, hd_out, hd_host, hd_bus;
    logic                  hclk, hcs_n, hrd_n, hwr_n, hoe, hwait_n, herr_n, ext_mem, boot, irq;
    logic [19:0]           haddr;
    logic [3:0]            hbw_n, hbe_n;
    hmps_pkg::hmps_strap_t strap;
    hmps_pkg::hmps_req_t   req;
    hmps_pkg::hmps_rsp_t   rsp = '0;
    hmps_pkg::hmps_req_t   seen[$];
    int                    n_mismatch, n_tests, cyc;

    assign hd_bus = hoe ? hd_out : hd_host;

    hmps_top dut (
        .CLK(clk), .RST(rst), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr),
        .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
        .HOST_PORT_SELECT(strap.port), .BURST_CONTROLLER_SELECT(strap.burst),
        .HOST_SYNC_SELECT(strap.sync), .ADDR_DATA_MUX_SELECT(strap.mux), .HOST_BUS_CLOCK(hclk),
        .HOST_CHIP_SELECT_N(hcs_n), .HOST_PAGE_SELECT_N(1'b1), .HOST_ADDRESS(haddr),
        .HOST_READ_STROBE_N(hrd_n), .HOST_WRITE_STROBE_N(hwr_n), .HOST_BYTE_WRITE_N(hbw_n),
        .HOST_BYTE_ENABLE_N(hbe_n), .HOST_DATA_IN(hd_bus), .HOST_DATA_OUT(hd_out), .HOST_DATA_OE(hoe),
        .HOST_WAIT_N(hwait_n), .HOST_ERROR_N(herr_n), .INT_REQ(req), .INT_RSP(rsp),
        .EXT_MEM_MODE(ext_mem), .HOST_BOOT_ONLY(boot), .IRQ(irq)
    );

    hmps_host_model host (
        .clk(clk), .wait_n(hwait_n), .error_n(herr_n), .bus_in(hd_bus), .bus_clk(hclk), .cs_n(hcs_n),
        .addr(haddr), .rd_n(hrd_n), .wr_n(hwr_n), .bw_n(hbw_n), .be_n(hbe_n), .data(hd_host)
    );

    // ==========================================================
    // Clock, internal responder, timeout
    always #4 clk = ~clk;

    // Read data is a known function of the address so the host side can predict it
    always @(posedge clk)
    begin
        rsp.ack   <= req.valid && !rsp.ack;
        rsp.err   <= rsp_err;
        rsp.rdata <= {11'h000, req.addr} ^ 32'hA5A5_0000;
        if (req.valid && !rsp.ack)
            seen.push_back(req);
        cyc <= cyc + 1;
        if (cyc == 20000)
        begin
            n_mismatch++;
            report_and_stop();
        end
    end

    // ==========================================================
    // Shared tasks
    task automatic chk(input logic [63:0] got, input logic [63:0] exp, input string m);
        n_tests++;
        if (got !== exp)
        begin
            $display("[ERR] %0t %s got %h exp %h", $time, m, got, exp);
            n_mismatch++;
        end
    endtask

    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                       output logic [31:0] q, output logic e);
        @(posedge clk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge clk);
        penable <= 1'b1;
        do
            @(posedge clk);
        while (pready !== 1'b1);
        q = prdata;
        e = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic do_reset(input logic [3:0] s);
        @(posedge clk);
        rst   <= 1'b1;
        strap <= s;
        repeat (12) @(posedge clk);
        rst <= 1'b0;
        repeat (6) @(posedge clk);
        seen.delete();
    endtask

    // ==========================================================
    // Scenarios
    task automatic t_modes;
        logic [3:0]  s [5] = '{4'h0, 4'h8, 4'hA, 4'hF, 4'hC};
        logic [1:0]  m [5] = '{2'h0, 2'h1, 2'h3, 2'h2, 2'h0};
        logic [31:0] q;
        logic        e;
        for (int i = 0; i < 5; i++)
        begin
            do_reset(s[i]);
            strap <= ~s[i];
            repeat (4) @(posedge clk);
            apb(1'b0, 12'h004, 32'h0000_0000, q, e);
            chk(q & 32'h0000_0103, {23'h0, 1'b1, 6'h00, m[i]}, "latched mode");
            chk(ext_mem, m[i] == 2'h0, "ext mem mode");
            chk(boot, m[i] != 2'h0, "host boot only");
            apb(1'b0, 12'h008, 32'h0000_0000, q, e);
            chk(q[2], i == 4, "bad strap flag");
        end
        $display("TB: modes done");
    endtask

    task automatic t_async;
        logic [31:0] q;
        logic        e;
        int          nb;
        do_reset(4'h8);
        apb(1'b0, 12'h000, 32'h0000_0000, q, e);
        chk(q, 32'h0000_0003, "ctrl reset");
        apb(1'b0, 12'h100, 32'h0000_0000, q, e);
        chk({q, e}, 33'h0_0000_0001, "unmapped");
        apb(1'b1, 12'h00C, 32'h0000_0001, q, e);
        host.xfer(1'b0, 20'hF_9800, 32'h0000_0000, 1'b0, 1, nb, q, e);
        chk(nb, 1, "async beat");
        chk(q, 32'hA5BA_3000, "read data");
        chk({seen[0].periph, seen[0].addr}, 22'h3F_3000, "periph base");
        chk(hoe, 1'b0, "bus released");
        chk(irq, 1'b1, "done irq");
        apb(1'b1, 12'h008, 32'h0000_0001, q, e);
        @(posedge clk);
        chk(irq, 1'b0, "irq cleared");
        host.xfer(1'b0, 20'hF_97FE, 32'h0000_0000, 1'b0, 1, nb, q, e);
        chk({seen[1].periph, seen[1].addr}, 22'h1F_2FFC, "below periph");
        apb(1'b0, 12'h010, 32'h0000_0000, q, e);
        chk(q, 32'h0000_0002, "count");
        apb(1'b1, 12'h000, 32'h0000_0002, q, e);
        host.xfer(1'b0, 20'h0_0100, 32'h0000_0000, 1'b0, 1, nb, q, e);
        chk({seen.size(), e}, 33'h0_0000_0005, "refused access");
        apb(1'b1, 12'h000, 32'h0000_0003, q, e);
        apb(1'b1, 12'h008, 32'h0000_0002, q, e);
        rsp_err <= 1'b1;
        host.xfer(1'b0, 20'h0_0100, 32'h0000_0000, 1'b0, 1, nb, q, e);
        rsp_err <= 1'b0;
        chk(e, 1'b1, "error out");
        apb(1'b0, 12'h008, 32'h0000_0000, q, e);
        chk(q[1], 1'b1, "error flag");
        $display("TB: async done");
    endtask

    task automatic t_sync;
        logic [31:0] q;
        logic        e;
        int          nb;
        do_reset(4'hA);
        host.xfer(1'b1, 20'h0_0040, 32'h1234_5678, 1'b0, 1, nb, q, e);
        chk(seen.size(), 0, "no host clock");
        host.xfer(1'b1, 20'h0_0040, 32'h1234_5678, 1'b1, 1, nb, q, e);
        chk({seen[0].write, seen[0].addr}, 22'h20_0080, "sync write addr");
        chk(seen[0].wdata, 32'h1234_5678, "sync write data");
        chk(seen[0].be, 4'hF, "lanes");
        do_reset(4'hF);
        host.xfer(1'b0, 20'h0_0010, 32'h0000_0000, 1'b1, 2, nb, q, e);
        chk(nb, 2, "burst beats");
        chk({seen.size(), seen[1].addr}, 53'h0_0000_0040_0024, "burst next addr");
        chk(q, 32'hA5A5_0024, "burst data");
        $display("TB: sync done");
    endtask

    task automatic report_and_stop;
        $display("TB: %0d checks, %0d mismatches", n_tests, n_mismatch);
        if (n_mismatch == 0 && n_tests > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    initial
    begin
        clk = 1'b0;
        rst = 1'b1;
        {psel, penable, pwrite, rsp_err} = 4'h0;
        paddr = 12'h000;
        pwdata = 32'h0000_0000;
        strap = 4'h8;
        {n_mismatch, n_tests, cyc} = '0;
        t_modes();
        t_async();
        t_sync();
        report_and_stop();
    end
endmodule
`default_nettype wire
